// *** rtl/bcu_pkg.sv ***
// package for the bridge configuration header upper register bank
package bcu_pkg;

   // configuration byte offsets
   localparam logic [7:0]  OFF_IO_BASE_HIGH    = 8'h30;
   localparam logic [7:0]  OFF_IO_LIMIT_HIGH   = 8'h32;
   localparam logic [7:0]  OFF_CAP_PTR         = 8'h34;
   localparam logic [7:0]  OFF_IRQ_LINE        = 8'h3c;
   localparam logic [7:0]  OFF_IRQ_PIN         = 8'h3d;
   localparam logic [7:0]  OFF_BRIDGE_CTRL     = 8'h3e;

   // reset and hardwired values
   localparam logic [15:0] RST_IO_BASE_HIGH    = 16'h0000;
   localparam logic [15:0] RST_IO_LIMIT_HIGH   = 16'h0000;
   localparam logic [7:0]  VAL_CAP_PTR         = 8'h50;
   localparam logic [7:0]  RST_IRQ_LINE        = 8'hff;
   localparam logic [7:0]  VAL_IRQ_PIN         = 8'h00;
   localparam logic [15:0] RST_BRIDGE_CTRL     = 16'h0000;

   // bridge control field positions
   localparam int          BCTL_RSVD_MSB       = 15;
   localparam int          BCTL_RSVD_LSB       = 12;
   localparam int          BCTL_DT_ERR_EN      = 11;
   localparam int          BCTL_DT_FLAG        = 10;
   localparam int          BCTL_DT_DN_SEL      = 9;
   localparam int          BCTL_DT_UP_SEL      = 8;
   localparam int          BCTL_LOW_MSB        = 7;

   // cycles from request to acknowledge
   localparam int          CFG_ACK_LATENCY     = 1;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [5:0]  dw_addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bcu_cfg_req_t;

   typedef struct packed {
      logic        ack;
      logic        hit;
      logic [31:0] rdata;
   } bcu_cfg_rsp_t;

   typedef struct packed {
      logic [15:0]  io_window_base_high;
      logic [15:0]  io_window_limit_high;
      logic [7:0]   irq_line_scratch;
      bcu_cfg_rsp_t rsp;
      logic         bctl_low_wr;
      logic [7:0]   bctl_low_wdata;
   } bcu_state_t;

   localparam bcu_state_t BCU_STATE_RST = '{
      io_window_base_high:  RST_IO_BASE_HIGH,
      io_window_limit_high: RST_IO_LIMIT_HIGH,
      irq_line_scratch:     RST_IRQ_LINE,
      rsp:                  '{ack: 1'b0, hit: 1'b0, rdata: 32'h0000_0000},
      bctl_low_wr:          1'b0,
      bctl_low_wdata:       RST_BRIDGE_CTRL[7:0]
   };

endpackage

// *** rtl/bcu_regs.sv ***
// upper type-1 header registers: io window high halves, cap pointer, irq bytes, bridge control
`timescale 1ns/1ps

// Contract
// - io window base high half at 30h, read/write, resets to 0000h
// - io window limit high half at 32h, read/write, resets to 0000h
// - byte 34h is read-only and always returns 50h
// - byte 3Ch is read/write scratch, resets to FFh
// - interrupt line byte is storage only, steering nothing
// - byte 3Dh is read-only and returns 00h
// - interrupt pin value never gates forwarded downstream interrupts
// - bridge control at 3Eh, sixteen bits, upper byte reads 00h, low byte reads bctl_low_in and is not reset here
// - bridge control bits 15:12 read as zero
// - bit 11 discard timeout error report enable reads zero
// - bit 10 discard timeout flag reads zero
// - bit 9 downstream discard timeout select reads zero
// - bit 8 upstream discard timeout select reads zero
module bcu_regs
   import bcu_pkg::*;
(
   input  wire logic         core_clk,              // core clock, 250 MHz
   input  wire logic         rst_b,                 // synchronous reset, active low
   input  wire bcu_cfg_req_t cfg_req,               // configuration request
   output bcu_cfg_rsp_t      cfg_rsp,               // configuration answer
   output logic [15:0]       io_window_base_high,   // base high half to window decode
   output logic [15:0]       io_window_limit_high,  // limit high half to window decode
   input  wire logic [7:0]   bctl_low_in,           // bridge control bits 7:0 from owner
   output logic              bctl_low_wr,           // pulse: write to bridge control byte 0
   output logic [7:0]        bctl_low_wdata         // data for that write
);

   localparam logic [5:0] DW_IO_WIN  = OFF_IO_BASE_HIGH[7:2];
   localparam logic [5:0] DW_CAP     = OFF_CAP_PTR[7:2];
   localparam logic [5:0] DW_IRQ_BCT = OFF_IRQ_LINE[7:2];

   bcu_state_t s;
   bcu_state_t next_s;

   // byte-lane merge of a 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // bridge control as read: upper byte hardwired, lower byte from its owner
   function automatic logic [15:0] bctl_view(input logic [7:0] low);
      logic [15:0] r;
      r = RST_BRIDGE_CTRL;
      r[BCTL_RSVD_MSB:BCTL_RSVD_LSB] = 4'h0;
      r[BCTL_DT_ERR_EN] = 1'b0;
      r[BCTL_DT_FLAG] = 1'b0;
      r[BCTL_DT_DN_SEL] = 1'b0;
      r[BCTL_DT_UP_SEL] = 1'b0;
      r[BCTL_LOW_MSB:0] = low;
      return r;
   endfunction

   always_comb begin
      next_s = s;
      next_s.rsp.ack = cfg_req.valid;
      next_s.rsp.hit = 1'b0;
      next_s.rsp.rdata = 32'h0000_0000;
      next_s.bctl_low_wr = 1'b0;
      if (cfg_req.valid) begin
         case (cfg_req.dw_addr)
            DW_IO_WIN: begin
               next_s.rsp.hit = 1'b1;
               if (cfg_req.write) begin
                  next_s.io_window_base_high =
                     merge16(s.io_window_base_high, cfg_req.wdata[15:0],
                             cfg_req.be[1:0]);
                  next_s.io_window_limit_high =
                     merge16(s.io_window_limit_high, cfg_req.wdata[31:16],
                             cfg_req.be[3:2]);
               end else begin
                  next_s.rsp.rdata = {s.io_window_limit_high, s.io_window_base_high};
               end
            end
            DW_CAP: begin
               next_s.rsp.hit = 1'b1;
               if (!cfg_req.write) begin
                  next_s.rsp.rdata = {24'h00_0000, VAL_CAP_PTR};
               end
            end
            DW_IRQ_BCT: begin
               next_s.rsp.hit = 1'b1;
               if (cfg_req.write) begin
                  if (cfg_req.be[0]) begin
                     next_s.irq_line_scratch = cfg_req.wdata[7:0];
                  end
                  if (cfg_req.be[2]) begin
                     next_s.bctl_low_wr = 1'b1;
                     next_s.bctl_low_wdata = cfg_req.wdata[23:16];
                  end
               end else begin
                  // pin byte is a constant and feeds no forwarding path
                  next_s.rsp.rdata = {bctl_view(bctl_low_in), VAL_IRQ_PIN,
                                      s.irq_line_scratch};
               end
            end
            default: begin
               next_s.rsp.hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s <= BCU_STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // scratch line byte is deliberately not routed anywhere but readback
   assign cfg_rsp              = s.rsp;
   assign io_window_base_high  = s.io_window_base_high;
   assign io_window_limit_high = s.io_window_limit_high;
   assign bctl_low_wr          = s.bctl_low_wr;
   assign bctl_low_wdata       = s.bctl_low_wdata;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_read(logic [5:0] a);
      cfg_req.valid && !cfg_req.write && cfg_req.dw_addr == a;
   endsequence

   sequence s_write(logic [5:0] a);
      cfg_req.valid && cfg_req.write && cfg_req.dw_addr == a;
   endsequence

   sequence s_answer;
      cfg_rsp.ack && cfg_rsp.hit;
   endsequence

   a_ack_follows_req: assert property (cfg_req.valid |-> ##CFG_ACK_LATENCY cfg_rsp.ack)
      else $error("request not acknowledged after one cycle");

   a_no_stray_ack: assert property (!cfg_req.valid |=> !cfg_rsp.ack)
      else $error("acknowledge without request");

   a_base_write: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[1:0] == 2'b11 |=>
      io_window_base_high == $past(cfg_req.wdata[15:0]))
      else $error("io base high half not written");

   a_limit_write: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[3:2] == 2'b11 |=>
      io_window_limit_high == $past(cfg_req.wdata[31:16]))
      else $error("io limit high half not written");

   a_window_readback: assert property (
      s_read(DW_IO_WIN) |=> s_answer ##0
      cfg_rsp.rdata == {$past(io_window_limit_high), $past(io_window_base_high)})
      else $error("io window readback wrong");

   a_cap_ptr_const: assert property (
      s_read(DW_CAP) |=> s_answer ##0 cfg_rsp.rdata[7:0] == VAL_CAP_PTR)
      else $error("capability pointer not 50h");

   a_line_reset: assert property (
      !$past(rst_b) |-> s.irq_line_scratch == RST_IRQ_LINE)
      else $error("interrupt line not FFh after reset");

   a_line_write: assert property (
      s_write(DW_IRQ_BCT) ##0 cfg_req.be[0] |=>
      s.irq_line_scratch == $past(cfg_req.wdata[7:0]))
      else $error("interrupt line not written");

   a_line_isolated: assert property (
      s_write(DW_IRQ_BCT) ##0 cfg_req.be == 4'h1 |=>
      $stable(io_window_base_high) && $stable(io_window_limit_high) && !bctl_low_wr)
      else $error("interrupt line write disturbed other state");

   a_pin_zero: assert property (
      s_read(DW_IRQ_BCT) |=> s_answer ##0 cfg_rsp.rdata[15:8] == VAL_IRQ_PIN)
      else $error("interrupt pin not 00h");

   a_bctl_low_view: assert property (
      s_read(DW_IRQ_BCT) |=> cfg_rsp.rdata[23:16] == $past(bctl_low_in))
      else $error("bridge control low byte readback wrong");

   a_bctl_rsvd: assert property (
      s_read(DW_IRQ_BCT) |=> cfg_rsp.rdata[31:28] == 4'h0)
      else $error("bridge control reserved bits not zero");

   a_dt_err_en: assert property (
      s_read(DW_IRQ_BCT) |=> !cfg_rsp.rdata[16 + BCTL_DT_ERR_EN])
      else $error("discard timeout error enable not zero");

   a_dt_flag: assert property (
      s_read(DW_IRQ_BCT) |=> !cfg_rsp.rdata[16 + BCTL_DT_FLAG])
      else $error("discard timeout flag not zero");

   a_dt_dn_sel: assert property (
      s_read(DW_IRQ_BCT) |=> !cfg_rsp.rdata[16 + BCTL_DT_DN_SEL])
      else $error("downstream discard timeout select not zero");

   a_dt_up_sel: assert property (
      s_read(DW_IRQ_BCT) |=> !cfg_rsp.rdata[16 + BCTL_DT_UP_SEL])
      else $error("upstream discard timeout select not zero");

   a_masked_hold: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be == 4'h0 |=>
      $stable(io_window_base_high) && $stable(io_window_limit_high))
      else $error("disabled byte lanes changed io window");

   a_line_masked: assert property (
      s_write(DW_IRQ_BCT) ##0 !cfg_req.be[0] |=> $stable(s.irq_line_scratch))
      else $error("interrupt line changed without its byte enable");

   // a bridge control byte 0 write is the only source of the low strobe
   sequence s_bctl_write;
      s_write(DW_IRQ_BCT) ##0 cfg_req.be[2];
   endsequence

   // a request that lands on none of the three claimed dwords
   sequence s_unclaimed;
      cfg_req.valid && cfg_req.dw_addr != DW_IO_WIN && cfg_req.dw_addr != DW_CAP &&
      cfg_req.dw_addr != DW_IRQ_BCT;
   endsequence

   // any read, whatever the address
   sequence s_any_read;
      cfg_req.valid && !cfg_req.write;
   endsequence

   a_bctl_wr_pulse: assert property (
      s_bctl_write |=> bctl_low_wr && bctl_low_wdata == $past(cfg_req.wdata[23:16]))
      else $error("bridge control low write strobe or data wrong");

   a_bctl_wr_quiet: assert property (
      !(cfg_req.valid && cfg_req.write && cfg_req.dw_addr == DW_IRQ_BCT && cfg_req.be[2])
      |=> !bctl_low_wr && $stable(bctl_low_wdata))
      else $error("bridge control low strobe without its write");

   a_rsp_idle: assert property (
      !cfg_rsp.ack |-> !cfg_rsp.hit && cfg_rsp.rdata == 32'h0000_0000)
      else $error("answer fields not zero outside acknowledge");

   a_write_no_data: assert property (
      cfg_req.valid && cfg_req.write |=> cfg_rsp.rdata == 32'h0000_0000)
      else $error("write answered with data");

   a_window_write_answer: assert property (
      s_write(DW_IO_WIN) |=> s_answer ##0 cfg_rsp.rdata == 32'h0000_0000)
      else $error("io window write not answered as a hit");

   a_cap_write_answer: assert property (
      s_write(DW_CAP) |=> s_answer ##0 cfg_rsp.rdata == 32'h0000_0000)
      else $error("capability write not answered as a hit");

   a_unclaimed_miss: assert property (
      s_unclaimed |=> cfg_rsp.ack && !cfg_rsp.hit && cfg_rsp.rdata == 32'h0000_0000)
      else $error("unclaimed address answered as a hit");

   a_claimed_hit: assert property (
      cfg_req.valid && (cfg_req.dw_addr == DW_IO_WIN || cfg_req.dw_addr == DW_CAP ||
      cfg_req.dw_addr == DW_IRQ_BCT) |=> s_answer)
      else $error("claimed address answered as a miss");

   a_bctl_read_answer: assert property (
      s_read(DW_IRQ_BCT) |=> s_answer)
      else $error("bridge control dword read not answered as a hit");

   a_cap_upper_zero: assert property (
      s_read(DW_CAP) |=> cfg_rsp.rdata[31:8] == 24'h00_0000)
      else $error("capability dword upper bytes not zero");

   a_line_readback: assert property (
      s_read(DW_IRQ_BCT) |=> cfg_rsp.rdata[7:0] == $past(s.irq_line_scratch))
      else $error("interrupt line readback wrong");

   a_base_lane0: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[1:0] == 2'b01 |=>
      io_window_base_high == {$past(io_window_base_high[15:8]), $past(cfg_req.wdata[7:0])})
      else $error("io base low lane merge wrong");

   a_base_lane1: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[1:0] == 2'b10 |=>
      io_window_base_high == {$past(cfg_req.wdata[15:8]), $past(io_window_base_high[7:0])})
      else $error("io base high lane merge wrong");

   a_limit_lane0: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[3:2] == 2'b01 |=>
      io_window_limit_high == {$past(io_window_limit_high[15:8]), $past(cfg_req.wdata[23:16])})
      else $error("io limit low lane merge wrong");

   a_limit_lane1: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[3:2] == 2'b10 |=>
      io_window_limit_high == {$past(cfg_req.wdata[31:24]), $past(io_window_limit_high[7:0])})
      else $error("io limit high lane merge wrong");

   a_base_masked: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[1:0] == 2'b00 |=> $stable(io_window_base_high))
      else $error("io base changed without its byte enables");

   a_limit_masked: assert property (
      s_write(DW_IO_WIN) ##0 cfg_req.be[3:2] == 2'b00 |=> $stable(io_window_limit_high))
      else $error("io limit changed without its byte enables");

   a_cap_write_inert: assert property (
      s_write(DW_CAP) |=> $stable(io_window_base_high) && $stable(io_window_limit_high) &&
      $stable(s.irq_line_scratch) && !bctl_low_wr)
      else $error("write to capability dword changed state");

   a_read_inert: assert property (
      s_any_read |=> $stable(io_window_base_high) && $stable(io_window_limit_high) &&
      $stable(s.irq_line_scratch) && !bctl_low_wr)
      else $error("read changed register state");

   a_window_write_local: assert property (
      s_write(DW_IO_WIN) |=> $stable(s.irq_line_scratch) && !bctl_low_wr)
      else $error("io window write disturbed interrupt line or strobe");

   a_pin_write_inert: assert property (
      s_write(DW_IRQ_BCT) ##0 !cfg_req.be[0] && !cfg_req.be[2] |=>
      $stable(s.irq_line_scratch) && !bctl_low_wr)
      else $error("write to read-only bytes changed state");

   a_idle_hold: assert property (
      !cfg_req.valid |=> $stable(io_window_base_high) && $stable(io_window_limit_high) &&
      $stable(s.irq_line_scratch))
      else $error("register changed without a request");

   a_reset_state: assert property (
      !$past(rst_b) |-> io_window_base_high == RST_IO_BASE_HIGH &&
      io_window_limit_high == RST_IO_LIMIT_HIGH && !bctl_low_wr && !cfg_rsp.ack &&
      bctl_low_wdata == RST_BRIDGE_CTRL[BCTL_LOW_MSB:0])
      else $error("register outputs not at reset values");

endmodule

// *** testbench/bcu_host_model.sv ***
// upstream requester model: issues one config request and returns its answer
`timescale 1ns/1ps
module bcu_host_model
   import bcu_pkg::*;
(
   input  wire logic         core_clk, // core clock
   output bcu_cfg_req_t      cfg_req,  // request to the register bank
   input  wire bcu_cfg_rsp_t cfg_rsp   // answer from the register bank
);
   initial cfg_req = '0;
   // request stands for its taking edge only; released fields flip so stale data is caught
   task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                       input logic [31:0] wd, output bcu_cfg_rsp_t rsp);
      @(posedge core_clk);
      cfg_req <= '{valid: 1'b1, write: wr, dw_addr: dw, be: be, wdata: wd};
      @(posedge core_clk);
      cfg_req <= '{valid: 1'b0, write: ~wr, dw_addr: ~dw, be: ~be, wdata: ~wd};
      // the answer launched by the taking edge is sampled at the edge after it
      @(posedge core_clk);
      rsp = cfg_rsp;
   endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the upper bridge header register bank
`timescale 1ns/1ps
module tb;
   import bcu_pkg::*;
   logic         core_clk;
   logic         rst_b;
   bcu_cfg_req_t cfg_req;
   bcu_cfg_rsp_t cfg_rsp;
   logic [15:0]  io_window_base_high;
   logic [15:0]  io_window_limit_high;
   logic [7:0]   bctl_low_in;
   logic         bctl_low_wr;
   logic [7:0]   bctl_low_wdata;
   int           err_count;
   int           n_compared;
   bcu_cfg_rsp_t r;

   bcu_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .io_window_base_high(io_window_base_high), .io_window_limit_high(io_window_limit_high),
      .bctl_low_in(bctl_low_in), .bctl_low_wr(bctl_low_wr), .bctl_low_wdata(bctl_low_wdata));
   bcu_host_model i_host (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
   endtask

   task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd,
                     input logic hit);
      i_host.xfer(1'b1, dw, be, wd, r);
      chk({30'h0, r.ack, r.hit}, {30'h0, 1'b1, hit}, "write ack/hit");
      chk(r.rdata, 32'h0, "write rdata");
   endtask

   task automatic rd(input logic [5:0] dw, input logic hit, input logic [31:0] exp);
      i_host.xfer(1'b0, dw, 4'hf, 32'h0, r);
      chk({30'h0, r.ack, r.hit}, {30'h0, 1'b1, hit}, "read ack/hit");
      chk(r.rdata, exp, "read data");
   endtask

   task automatic t_reset_values;
      rd(6'h0c, 1'b1, 32'h0000_0000);
      rd(6'h0d, 1'b1, 32'h0000_0050);
      rd(6'h0f, 1'b1, {8'h00, 8'h3c, 8'h00, 8'hff});
      chk({16'h0, io_window_base_high}, 32'h0, "base port");
      chk({16'h0, io_window_limit_high}, 32'h0, "limit port");
      $display("test reset_values done");
   endtask

   task automatic t_byte_enables;
      wr(6'h0c, 4'b0101, 32'h1122_3344, 1'b1);
      chk({io_window_limit_high, io_window_base_high}, 32'h0022_0044, "partial write");
      wr(6'h0c, 4'b1010, 32'haabb_ccdd, 1'b1);
      rd(6'h0c, 1'b1, 32'haa22_cc44);
      chk({io_window_limit_high, io_window_base_high}, 32'haa22_cc44, "window ports");
      $display("test byte_enables done");
   endtask

   task automatic t_readonly;
      wr(6'h0d, 4'hf, 32'hffff_ffff, 1'b1);
      rd(6'h0d, 1'b1, 32'h0000_0050);
      wr(6'h0f, 4'b1110, 32'hffff_a55a, 1'b1);
      chk({31'h0, bctl_low_wr}, 32'h1, "low strobe");
      chk({24'h0, bctl_low_wdata}, 32'hff, "low data");
      @(posedge core_clk);
      bctl_low_in <= 8'h81;
      rd(6'h0f, 1'b1, {8'h00, 8'h81, 8'h00, 8'hff});
      chk({31'h0, bctl_low_wr}, 32'h0, "no strobe on read");
      wr(6'h0f, 4'b0001, 32'h0000_0007, 1'b1);
      chk({31'h0, bctl_low_wr}, 32'h0, "no strobe without be2");
      chk({io_window_limit_high, io_window_base_high}, 32'haa22_cc44, "line inert");
      rd(6'h0f, 1'b1, {8'h00, 8'h81, 8'h00, 8'h07});
      $display("test readonly done");
   endtask

   task automatic t_unmapped;
      wr(6'h0e, 4'hf, 32'hffff_ffff, 1'b0);
      rd(6'h0e, 1'b0, 32'h0);
      rd(6'h00, 1'b0, 32'h0);
      rd(6'h3f, 1'b0, 32'h0);
      rd(6'h0c, 1'b1, 32'haa22_cc44);
      $display("test unmapped done");
   endtask

   task automatic t_full_masked;
      wr(6'h0c, 4'hf, 32'h5566_7788, 1'b1);
      chk({io_window_limit_high, io_window_base_high}, 32'h5566_7788, "full write");
      wr(6'h0c, 4'h0, 32'hffff_ffff, 1'b1);
      wr(6'h0c, 4'b1100, 32'h99aa_ffff, 1'b1);
      rd(6'h0c, 1'b1, 32'h99aa_7788);
      wr(6'h0f, 4'b1010, 32'hffff_ffff, 1'b1);
      chk({31'h0, bctl_low_wr}, 32'h0, "no strobe on pin or high byte");
      rd(6'h0f, 1'b1, {8'h00, 8'h81, 8'h00, 8'h07});
      $display("test full_masked done");
   endtask

   task automatic t_mid_reset;
      do_reset;
      rd(6'h0c, 1'b1, 32'h0000_0000);
      rd(6'h0f, 1'b1, {8'h00, 8'h81, 8'h00, 8'hff});
      chk({24'h0, bctl_low_wdata}, 32'h0, "low data after reset");
      $display("test mid_reset done");
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      $display("MISMATCH t=%0t run timed out", $time);
      summarize;
   end

   initial begin
      err_count = 0;
      n_compared = 0;
      rst_b = 1'b0;
      bctl_low_in = 8'h3c;
      do_reset;
      t_reset_values;
      t_byte_enables;
      t_readonly;
      t_unmapped;
      t_full_masked;
      t_mid_reset;
      summarize;
   end
endmodule
